// ===== shared/bscan_pkg.sv
`default_nettype none
package bscan_pkg;
   // Chain geometry and pin grouping.
   localparam int CHAIN_LEN = 57;
   localparam int PIN_COUNT = 28;
   localparam int RST_CELL_POS = 40;
   localparam int LOW_GROUP_START = 8;
   localparam int UPPER_TOP = 56;
   localparam int LOWER_TOP = 55;
   localparam int ANALOG_W = 8;
   // Instruction codes seen from the instruction register.
   localparam logic [3:0] OP_EXTEST = 4'h0;
   localparam logic [3:0] OP_SAMPLE_PRELOAD = 4'h2;
   localparam logic [3:0] OP_TEST_RESET = 4'hC;
   // Register bus layout.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] REG_RESET_CAUSE = 8'h34;
   localparam logic [7:0] REG_SYS_CTRL = 8'h35;
   localparam logic [7:0] SYS_CTRL_RESET = 8'h00;
   localparam logic [4:0] CAUSE_RESET = 5'h00;
   // Field positions in system_control_bits.
   localparam int BIT_TEST_IF_DISABLE = 7;
   localparam int BIT_PULLUP_DISABLE = 4;
   localparam int BIT_VECTOR_SELECT = 1;
   localparam int BIT_VECTOR_UNLOCK = 0;
   // Field positions in reset_cause_flags.
   localparam int BIT_TEST_RESET_FLAG = 4;
   localparam int BIT_WATCHDOG_FLAG = 3;
   localparam int BIT_BROWNOUT_FLAG = 2;
   localparam int BIT_EXTERNAL_FLAG = 1;
   localparam int BIT_POWERON_FLAG = 0;
   // Timed write window, in core clock cycles.
   localparam int TIMED_WINDOW_CYC = 4;
   localparam logic [2:0] TIMED_RELOAD = 3'(TIMED_WINDOW_CYC - 1);
   // Data register control from the test access port controller.
   typedef struct packed {
      logic capture;
      logic shift;
      logic update;
      logic [3:0] instr;
   } tap_ctl_t;
   // Pin-side sampling of the test clock and data.
   typedef struct packed {
      logic tck;
      logic tdi;
      tap_ctl_t ctl;
   } link_in_t;
endpackage : bscan_pkg
`default_nettype wire

// ===== src/boundary_scan_chain_ctrl.sv
// Function
// R1: Scan instructions force pull-ups off on every scanned pin.
// R2: Each pin cell folds control, output and input into two stages.
// R3: Input sample comes straight from pin; output is latch, control direction.
// R4: Pull-up enable is not-disable AND not-direction AND output latch.
// R5: Alternate functions sit outside the cell; chain sees the real pin.
// R6: Digital controls to analog circuitry are switched off during scan.
// R7: No clock on the clock-output pin under scan instructions.
// R8: The clock-output signal is never captured by the chain.
// R9: A capture-only cell observes the active-low reset pin.
// R10: Bit 0 is shifted in first and shifted out first.
// R11: 57 cells; port B pairs at 56..41, reset cell at 40.
// R12: Port D pairs at 39..24, port C pins 0,1,6,7 at 23..16.
// R13: Port A in reverse pin order, bits 15 down to 0.
// R14: Data cell is the first stage, control cell the second.
// R15: The four test-access pins have no cells in the chain.
// R16: Interface-disable bit 7 low enables port with fuse; resets to 0.
// R17: Disable bit changes only on two equal writes within four cycles.
// R18: Test-reset cause flag sets when the test reset register resets.
// R19: Test-reset flag clears on power-on or software zero write only.
// R20: External test captures pins and drives update latches onto pins.
// R21: Sample-preload captures pins and loads latches without driving pins.
// R22: Device held in reset while the test reset bit is high; here only while the test-reset instruction is loaded.
// R23: Without scan instructions pins follow normal port logic.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_chain_ctrl
   import bscan_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic tck_in,
   input wire logic tdi_in,
   input wire tap_ctl_t tap_ctl_in,
   output logic tdo_out,
   output logic tdo_sel_out,
   input wire logic test_interface_fuse_in,
   output logic test_interface_en_out,
   input wire logic [PIN_COUNT-1:0] pin_input_value_in,
   input wire logic [PIN_COUNT-1:0] pin_output_latch_in,
   input wire logic [PIN_COUNT-1:0] pin_direction_bit_in,
   output logic [PIN_COUNT-1:0] pin_out_out,
   output logic [PIN_COUNT-1:0] pin_oe_out,
   output logic [PIN_COUNT-1:0] pin_pullup_enable_out,
   input wire logic rst_pin_n_in,
   input wire logic clock_output_fuse_in,
   output logic clk_pin_out,
   input wire logic [ANALOG_W-1:0] analog_ctrl_in,
   output logic [ANALOG_W-1:0] analog_ctrl_out,
   output logic test_reset_out,
   input wire logic poweron_evt_in,
   input wire logic external_evt_in,
   input wire logic brownout_evt_in,
   input wire logic watchdog_evt_in,
   input wire logic [ADDR_W-1:0] reg_addr_in,
   input wire logic [DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [DATA_W-1:0] reg_rdata_out
);

   // Chain position of the data cell of pin k; the control cell sits one
   // below. Pins run B0..B7, D0..D7, C0,C1,C6,C7, A7..A0.
   function automatic int data_pos(input int k);
      if (k < LOW_GROUP_START)
         return UPPER_TOP - 2 * k;
      else
         return LOWER_TOP - 2 * k;
   endfunction : data_pos

   // Pull-up equation of a pin in normal operation.
   function automatic logic pullup_eqn(input logic pull_off,
                                       input logic dir,
                                       input logic latch);
      return ~pull_off & ~dir & latch;
   endfunction : pullup_eqn

   link_in_t sync1_r;
   link_in_t sync2_r;
   logic tck_d_r;
   logic [CHAIN_LEN-1:0] chain_r;
   logic [CHAIN_LEN-1:0] upd_r;
   logic [CHAIN_LEN-1:0] cap_vec;
   logic [PIN_COUNT-1:0] upd_data;
   logic [PIN_COUNT-1:0] upd_ctrl;
   logic [PIN_COUNT-1:0] pin_out_r;
   logic [PIN_COUNT-1:0] pin_oe_r;
   logic [PIN_COUNT-1:0] pullup_r;
   logic [PIN_COUNT-1:0] pin_out_nxt;
   logic [PIN_COUNT-1:0] pin_oe_nxt;
   logic [PIN_COUNT-1:0] pullup_nxt;
   logic [ANALOG_W-1:0] analog_r;
   logic tdo_r;
   logic rst_reg_r;
   logic clk_out_en_r;
   logic port_off_r;
   logic pullup_off_r;
   logic vec_select_r;
   logic vec_unlock_r;
   logic pend_val_r;
   logic [2:0] pend_cnt_r;
   logic [4:0] cause_r;
   logic [4:0] cause_nxt;
   logic [4:0] cause_keep;
   logic [4:0] cause_set;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] ctrl_val;

   // Test clock, data and port controller state cross into the core clock
   // through two flip-flops; only the second stage is read.
   always_ff @(posedge core_clk_in)
   begin
      sync1_r <= {tck_in, tdi_in, tap_ctl_in};
      sync2_r <= sync1_r;
      tck_d_r <= sync2_r.tck;
   end

   // Instruction decode and test clock edges.
   wire tap_en = test_interface_fuse_in & ~port_off_r; // [R16]
   wire [3:0] instr = sync2_r.ctl.instr;
   wire is_extest = tap_en && (instr == OP_EXTEST);
   wire is_sample = tap_en && (instr == OP_SAMPLE_PRELOAD);
   wire is_rst = tap_en && (instr == OP_TEST_RESET);
   wire bscan_act = is_extest | is_sample;
   wire tck_rise = tap_en & sync2_r.tck & ~tck_d_r;
   wire tck_fall = tap_en & ~sync2_r.tck & tck_d_r;
   wire tdi_s = sync2_r.tdi;
   wire bs_capture = tck_rise & bscan_act & sync2_r.ctl.capture;
   wire bs_shift = tck_rise & bscan_act & sync2_r.ctl.shift;
   wire bs_update = tck_rise & bscan_act & sync2_r.ctl.update;
   wire rst_shift = tck_rise & is_rst & sync2_r.ctl.shift;

   // Per-pin wiring of the two-stage cells. The data stage captures the raw
   // pin with no synchronizer, the control stage the applied direction.
   // Only the 28 port pins and the reset cell exist, so the test-access
   // pins and the clock output have no place in the chain.
   genvar k;
   generate
      for (k = 0; k < PIN_COUNT; k++)
      begin : g_cell
         localparam int DP = data_pos(k); // [R11] [R12] [R13]
         assign cap_vec[DP] = pin_input_value_in[k]; // [R3] [R5] [R14]
         assign cap_vec[DP-1] = pin_oe_r[k]; // [R2] [R14] [R15]
         assign upd_data[k] = upd_r[DP];
         assign upd_ctrl[k] = upd_r[DP-1];
      end
   endgenerate
   // The reset pin is observed only; nothing drives it from the chain.
   assign cap_vec[RST_CELL_POS] = rst_pin_n_in; // [R9] [R8]

   // Shift register: capture, or shift with new bits entering at the top
   // so that bit 0 leaves first.
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
         chain_r <= '0;
      else if (bs_capture)
         chain_r <= cap_vec; // [R20] [R21]
      else if (bs_shift)
         chain_r <= {tdi_s, chain_r[CHAIN_LEN-1:1]}; // [R10]
   end

   // Update latches load from the chain in both scan instructions.
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
         upd_r <= '0;
      else if (bs_update)
         upd_r <= chain_r; // [R20] [R21]
   end

   // Unlatched one-bit test reset register.
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
         rst_reg_r <= 1'b0;
      else if (rst_shift)
         rst_reg_r <= tdi_s;
   end
   assign test_reset_out = rst_reg_r & is_rst; // [R22]

   // Serial output changes on the falling test clock edge.
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
         tdo_r <= 1'b0;
      else if (tck_fall)
         tdo_r <= bscan_act ? chain_r[0] : (is_rst & rst_reg_r); // [R10]
   end
   assign tdo_out = tdo_r;
   assign tdo_sel_out = bscan_act | is_rst;

   // Pin drive: external test drives the update latches; sample-preload
   // and normal mode leave the port logic in charge.
   assign pin_out_nxt = is_extest ? upd_data : pin_output_latch_in; // [R23]
   assign pin_oe_nxt = is_extest ? upd_ctrl : pin_direction_bit_in; // [R20]
   always_comb
   begin
      for (int i = 0; i < PIN_COUNT; i++)
         pullup_nxt[i] = ~bscan_act & pullup_eqn(pullup_off_r, // [R1]
            pin_direction_bit_in[i], pin_output_latch_in[i]); // [R4]
   end

   // Registered pin outputs, analog controls and clock-output enable.
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         pin_out_r <= '0;
         pin_oe_r <= '0;
         pullup_r <= '0;
         analog_r <= '0;
         clk_out_en_r <= 1'b0;
      end
      else
      begin
         pin_out_r <= pin_out_nxt;
         pin_oe_r <= pin_oe_nxt;
         pullup_r <= pullup_nxt;
         analog_r <= bscan_act ? '0 : analog_ctrl_in; // [R6]
         clk_out_en_r <= clock_output_fuse_in & ~bscan_act; // [R7]
      end
   end
   assign pin_out_out = pin_out_r;
   assign pin_oe_out = pin_oe_r;
   assign pin_pullup_enable_out = pullup_r;
   assign analog_ctrl_out = analog_r;
   assign clk_pin_out = core_clk_in & clk_out_en_r;
   assign test_interface_en_out = tap_en;

   // Register bus decode.
   wire wr_ctrl = reg_wr_in && (reg_addr_in == REG_SYS_CTRL);
   wire wr_cause = reg_wr_in && (reg_addr_in == REG_RESET_CAUSE);
   wire rd_ctrl = reg_rd_in && (reg_addr_in == REG_SYS_CTRL);
   wire rd_cause = reg_rd_in && (reg_addr_in == REG_RESET_CAUSE);
   wire new_off = reg_wdata_in[BIT_TEST_IF_DISABLE];
   wire timed_ok = (pend_cnt_r != 3'h0) && (new_off == pend_val_r);

   // Control bits; the disable bit needs two equal writes in the window.
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
      begin
         port_off_r <= 1'h0; // [R16]
         pullup_off_r <= 1'h0;
         vec_select_r <= 1'h0;
         vec_unlock_r <= 1'h0;
         pend_val_r <= 1'b0;
         pend_cnt_r <= 3'h0;
      end
      else if (wr_ctrl)
      begin
         pullup_off_r <= reg_wdata_in[BIT_PULLUP_DISABLE];
         vec_select_r <= reg_wdata_in[BIT_VECTOR_SELECT];
         vec_unlock_r <= reg_wdata_in[BIT_VECTOR_UNLOCK];
         pend_val_r <= new_off;
         if (timed_ok)
         begin
            port_off_r <= new_off; // [R17]
            pend_cnt_r <= 3'h0;
         end
         else
            pend_cnt_r <= TIMED_RELOAD; // [R17]
      end
      else if (pend_cnt_r != 3'h0)
         pend_cnt_r <= pend_cnt_r - 3'h1;
   end

   // Reset cause flags: hardware sets win over software zero writes.
   assign cause_keep = wr_cause ? reg_wdata_in[4:0] : 5'h1F;
   always_comb
   begin
      cause_set = 5'h00;
      cause_set[BIT_TEST_RESET_FLAG] = test_reset_out; // [R18]
      cause_set[BIT_WATCHDOG_FLAG] = watchdog_evt_in;
      cause_set[BIT_BROWNOUT_FLAG] = brownout_evt_in;
      cause_set[BIT_EXTERNAL_FLAG] = external_evt_in;
      cause_set[BIT_POWERON_FLAG] = poweron_evt_in;
      cause_nxt = cause_r & cause_keep;
      if (poweron_evt_in)
         cause_nxt[BIT_TEST_RESET_FLAG] = 1'b0; // [R19]
      cause_nxt = cause_nxt | cause_set;
   end
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
         cause_r <= CAUSE_RESET;
      else
         cause_r <= cause_nxt; // [R19]
   end

   // Read data stands only in the cycle after the read strobe.
   always_comb
   begin
      ctrl_val = SYS_CTRL_RESET;
      ctrl_val[BIT_TEST_IF_DISABLE] = port_off_r;
      ctrl_val[BIT_PULLUP_DISABLE] = pullup_off_r;
      ctrl_val[BIT_VECTOR_SELECT] = vec_select_r;
      ctrl_val[BIT_VECTOR_UNLOCK] = vec_unlock_r;
   end
   always_ff @(posedge core_clk_in)
   begin
      if (srst_in)
         rdata_r <= '0;
      else if (rd_ctrl)
         rdata_r <= ctrl_val;
      else if (rd_cause)
         rdata_r <= {3'h0, cause_r};
      else
         rdata_r <= '0;
   end
   assign reg_rdata_out = rdata_r;

   // Checks on the scan, pin and register behaviour.
   AST_PULLUP_OFF: assert property ( // [R1]
      @(posedge core_clk_in) disable iff (srst_in)
      bscan_act |=> (pin_pullup_enable_out == '0))
      else $error("pull-up active during scan");
   AST_PULLUP_EQN: assert property ( // [R4]
      @(posedge core_clk_in) disable iff (srst_in)
      !bscan_act |=> pin_pullup_enable_out ==
      $past(~{PIN_COUNT{pullup_off_r}} & ~pin_direction_bit_in &
      pin_output_latch_in))
      else $error("pull-up equation wrong");
   AST_NORMAL_PINS: assert property ( // [R23]
      @(posedge core_clk_in) disable iff (srst_in)
      !is_extest |=> (pin_out_out == $past(pin_output_latch_in)) &&
      (pin_oe_out == $past(pin_direction_bit_in)))
      else $error("pins not following port logic");
   AST_EXTEST_DRIVE: assert property ( // [R20]
      @(posedge core_clk_in) disable iff (srst_in)
      is_extest |=> (pin_oe_out == $past(upd_ctrl)) &&
      (pin_out_out == $past(upd_data)))
      else $error("external test not driving latches");
   AST_CLK_GATED: assert property ( // [R7]
      @(posedge core_clk_in) disable iff (srst_in)
      bscan_act |=> !clk_out_en_r)
      else $error("clock output enabled during scan");
   AST_ANALOG_OFF: assert property ( // [R6]
      @(posedge core_clk_in) disable iff (srst_in)
      bscan_act |=> (analog_ctrl_out == '0))
      else $error("analog controls live during scan");
   AST_SHIFT_LSB: assert property ( // [R10]
      @(posedge core_clk_in) disable iff (srst_in)
      bs_shift |=> (chain_r[CHAIN_LEN-1] == $past(tdi_s)) &&
      (chain_r[CHAIN_LEN-2:0] == $past(chain_r[CHAIN_LEN-1:1])))
      else $error("shift direction wrong");
   AST_CAPTURE_RST: assert property ( // [R9]
      @(posedge core_clk_in) disable iff (srst_in)
      bs_capture |=> chain_r[RST_CELL_POS] == $past(rst_pin_n_in))
      else $error("reset cell not captured");
   // A change straight after a system reset comes from the reset itself.
   AST_DISABLE_TIMED: assert property ( // [R17]
      @(posedge core_clk_in) disable iff (srst_in)
      $changed(port_off_r) && !$past(srst_in) |->
      $past(wr_ctrl) && ($past(pend_cnt_r) != 3'h0))
      else $error("disable bit changed by single write");
   AST_TEST_RESET_FLAG: assert property ( // [R18]
      @(posedge core_clk_in) disable iff (srst_in)
      test_reset_out |=> cause_r[BIT_TEST_RESET_FLAG])
      else $error("test reset flag not set");
   AST_FLAG_KEEP: assert property ( // [R19]
      @(posedge core_clk_in) disable iff (srst_in)
      (external_evt_in || brownout_evt_in || watchdog_evt_in) &&
      !poweron_evt_in && !wr_cause && !test_reset_out |=>
      cause_r[BIT_TEST_RESET_FLAG] ==
      $past(cause_r[BIT_TEST_RESET_FLAG]))
      else $error("test reset flag changed by other reset");
   AST_SAMPLE_NOPIN: assert property ( // [R21]
      @(posedge core_clk_in) disable iff (srst_in)
      is_sample |=> pin_out_out == $past(pin_output_latch_in))
      else $error("sample-preload drove pins");
   AST_TRST_HOLD: assert property ( // [R22]
      @(posedge core_clk_in) disable iff (srst_in)
      rst_shift ##1 is_rst |-> test_reset_out == $past(tdi_s))
      else $error("test reset not following register");
   COV_EXTEST_UPDATE: cover property (@(posedge core_clk_in) disable iff
      (srst_in) bs_update && is_extest);
   COV_SAMPLE_CAPTURE: cover property (@(posedge core_clk_in) disable iff
      (srst_in) bs_capture && is_sample);
   COV_DISABLE_CHANGE: cover property (@(posedge core_clk_in) disable iff
      (srst_in) wr_ctrl && timed_ok);
   COV_TEST_RESET: cover property (@(posedge core_clk_in) disable iff
      (srst_in) test_reset_out);

endmodule : boundary_scan_chain_ctrl
`default_nettype wire

// ===== dv/tap_test_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module tap_test_ctrl_model
   import bscan_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic tdo_in,
   output var logic tck_out,
   output var logic tdi_out,
   output var tap_ctl_t ctl_out
);
   // The test clock stands low between frames; bypass is the idle opcode.
   initial
   begin
      tck_out = 1'h0;
      tdi_out = 1'h0;
      ctl_out = '{capture: 1'h0, shift: 1'h0, update: 1'h0, instr: 4'hF};
   end
   // Loads an opcode with all data register actions idle.
   task automatic set_ir(input logic [3:0] op);
      @(posedge core_clk_in);
      ctl_out <= '{capture: 1'h0, shift: 1'h0, update: 1'h0, instr: op};
      repeat (5) @(posedge core_clk_in);
   endtask : set_ir
   // One 160 ns test clock period; control changes well away from the rise.
   // The returned bit is the serial output left by the previous period.
   task automatic pulse(input tap_ctl_t c, input logic d, output logic q);
      @(posedge core_clk_in);
      ctl_out <= c;
      tdi_out <= d;
      repeat (2) @(posedge core_clk_in);
      q = tdo_in;
      tck_out <= 1'h1;
      repeat (3) @(posedge core_clk_in);
      tck_out <= 1'h0;
      repeat (2) @(posedge core_clk_in);
      tdi_out <= ~d;
   endtask : pulse
endmodule : tap_test_ctrl_model
`default_nettype wire

// ===== dv/test_boundary_scan_chain_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_boundary_scan_chain_ctrl
   import bscan_pkg::*;
;
   typedef struct packed {
      logic [7:0] sys;
      logic [7:0] rd;
      logic [27:0] latch;
      logic [27:0] dir;
      logic [27:0] pull;
   } row_t;
   localparam row_t ROWS [3] = '{
      '{8'h00, 8'h00, 28'hFFF0F0F, 28'h00F00FF, 28'hFF00F00},
      '{8'h10, 8'h10, 28'hFFF0F0F, 28'h00F00FF, 28'h0000000},
      '{8'h6F, 8'h03, 28'h5555555, 28'h3333333, 28'h4444444}};
   localparam logic [56:0] PAT = 57'h15A5AC33C9669F0;
   logic clk, srst, fuse, ckfuse, rst_n, ev_po, ev_ex, ev_bo, ev_wd;
   logic reg_wr, reg_rd, q;
   logic [7:0] reg_addr, reg_wdata, analog;
   logic [27:0] pin_in, latch, dir, exo, exe;
   logic [56:0] got, exp_ch;
   wire logic tck_w, tdi_w, tdo_w, tdo_sel, en, clk_pin, trst;
   wire tap_ctl_t ctl_w;
   wire logic [27:0] pout, poe, pull;
   wire logic [7:0] aout, rdata;
   int miscompares = 0;
   int tests_run = 0;
   tap_test_ctrl_model tap_test_ctrl_model_i (.core_clk_in(clk),
      .tdo_in(tdo_w), .tck_out(tck_w), .tdi_out(tdi_w), .ctl_out(ctl_w));
   boundary_scan_chain_ctrl boundary_scan_chain_ctrl_i (.core_clk_in(clk),
      .srst_in(srst), .tck_in(tck_w), .tdi_in(tdi_w), .tap_ctl_in(ctl_w),
      .tdo_out(tdo_w), .tdo_sel_out(tdo_sel), .test_interface_fuse_in(fuse),
      .test_interface_en_out(en), .pin_input_value_in(pin_in),
      .pin_output_latch_in(latch), .pin_direction_bit_in(dir),
      .pin_out_out(pout), .pin_oe_out(poe), .pin_pullup_enable_out(pull),
      .rst_pin_n_in(rst_n), .clock_output_fuse_in(ckfuse),
      .clk_pin_out(clk_pin), .analog_ctrl_in(analog),
      .analog_ctrl_out(aout), .test_reset_out(trst), .poweron_evt_in(ev_po),
      .external_evt_in(ev_ex), .brownout_evt_in(ev_bo),
      .watchdog_evt_in(ev_wd), .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
      .reg_rdata_out(rdata));
   // Free-running core clock at 50 MHz.
   always #10 clk = ~clk;
   // Chain position of the data cell of pin index k.
   function automatic int pos_of(input int k);
      return (k < 8) ? 56 - 2 * k : 55 - 2 * k;
   endfunction : pos_of
   // Expected captured chain from pin levels, drive enables and reset pin.
   function automatic logic [56:0] chain_of(input logic [27:0] d,
      input logic [27:0] c, input logic r);
      logic [56:0] ch;
      ch = '0;
      for (int k = 0; k < 28; k++)
      begin
         ch[pos_of(k)] = d[k];
         ch[pos_of(k) - 1] = c[k];
      end
      ch[40] = r;
      return ch;
   endfunction : chain_of
   function automatic tap_ctl_t mk(input logic c, input logic s,
      input logic u, input logic [3:0] op);
      return '{capture: c, shift: s, update: u, instr: op};
   endfunction : mk
   // Counts a comparison and reports a mismatch at once.
   task automatic chk(input string what, input logic [63:0] exp,
      input logic [63:0] seen);
      tests_run++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask : reg_write
   // Read data stand only in the cycle after the strobe.
   task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1;
      chk("reg_rdata", 64'(exp), 64'(rdata));
   endtask : reg_check
   // Samples the clock-output pin in the high half of the core clock.
   task automatic clk_check(input logic exp);
      @(posedge clk);
      #5;
      chk("clk_pin", 64'(exp), 64'(clk_pin));
   endtask : clk_check
   task automatic events(input logic po, input logic other);
      @(posedge clk);
      ev_po <= po;
      {ev_ex, ev_bo, ev_wd} <= {3{other}};
      @(posedge clk);
      {ev_po, ev_ex, ev_bo, ev_wd} <= 4'h0;
   endtask : events
   // Bounds the whole run.
   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      finish_test();
   end
   initial
   begin
      {clk, fuse, ckfuse, rst_n, srst} = 5'h1F;
      {ev_po, ev_ex, ev_bo, ev_wd, reg_wr, reg_rd} = 6'h00;
      {reg_addr, reg_wdata, analog} = {16'h0000, 8'hA5};
      {pin_in, latch, dir} = {28'hA5C396E, 28'h0F0F0F0, 28'hF0F0F0F};
      repeat (4) @(posedge clk);
      srst <= 1'h0;
      foreach (ROWS[i])
      begin
         reg_write(REG_SYS_CTRL, ROWS[i].sys);
         latch <= ROWS[i].latch;
         dir <= ROWS[i].dir;
         reg_check(REG_SYS_CTRL, ROWS[i].rd);
         repeat (2) @(posedge clk);
         chk("pin_pullup", 64'(ROWS[i].pull), 64'(pull));
         chk("pin_out", 64'(ROWS[i].latch), 64'(pout));
         chk("pin_oe", 64'(ROWS[i].dir), 64'(poe));
      end
      $display("test table done");
      srst <= 1'h1;
      @(posedge clk);
      srst <= 1'h0;
      reg_check(REG_SYS_CTRL, SYS_CTRL_RESET);
      reg_check(REG_RESET_CAUSE, 8'h00);
      reg_check(8'h36, 8'h00);
      chk("en", 64'h1, 64'(en));
      // An unprogrammed fuse keeps the port off whatever the bit says.
      @(posedge clk);
      fuse <= 1'h0;
      @(posedge clk);
      #1;
      chk("en", 64'h0, 64'(en));
      @(posedge clk);
      fuse <= 1'h1;
      $display("test reset done");
      reg_write(REG_SYS_CTRL, 8'h80);
      repeat (6) @(posedge clk);
      chk("en", 64'h1, 64'(en));
      reg_write(REG_SYS_CTRL, 8'h80);
      reg_write(REG_SYS_CTRL, 8'h80);
      reg_check(REG_SYS_CTRL, 8'h80);
      chk("en", 64'h0, 64'(en));
      tap_test_ctrl_model_i.set_ir(OP_SAMPLE_PRELOAD);
      chk("tdo_sel", 64'h0, 64'(tdo_sel));
      reg_write(REG_SYS_CTRL, 8'h00);
      reg_write(REG_SYS_CTRL, 8'h00);
      reg_check(REG_SYS_CTRL, 8'h00);
      chk("en", 64'h1, 64'(en));
      tap_test_ctrl_model_i.set_ir(4'hF);
      $display("test disable done");
      rst_n <= 1'h0;
      pin_in <= 28'hA5C396E;
      latch <= 28'h0F0F0F0;
      dir <= 28'hF0F0F0F;
      repeat (3) @(posedge clk);
      chk("analog", 64'hA5, 64'(aout));
      clk_check(1'h1);
      tap_test_ctrl_model_i.set_ir(OP_SAMPLE_PRELOAD);
      chk("pin_pullup", 64'h0, 64'(pull));
      chk("analog", 64'h0, 64'(aout));
      chk("tdo_sel", 64'h1, 64'(tdo_sel));
      clk_check(1'h0);
      tap_test_ctrl_model_i.pulse(mk(1, 0, 0, OP_SAMPLE_PRELOAD), 1'h0, q);
      for (int j = 0; j < 57; j++)
         tap_test_ctrl_model_i.pulse(mk(0, 1, 0, OP_SAMPLE_PRELOAD), PAT[j],
            got[j]);
      exp_ch = chain_of(pin_in, dir, 1'h0);
      chk("chain", 64'(exp_ch), 64'(got));
      chk("chain_b", 64'(exp_ch[56:41]), 64'(got[56:41]));
      chk("chain_rst", 64'(exp_ch[40]), 64'(got[40]));
      chk("chain_dc", 64'(exp_ch[39:16]), 64'(got[39:16]));
      chk("chain_a", 64'(exp_ch[15:0]), 64'(got[15:0]));
      tap_test_ctrl_model_i.pulse(mk(0, 0, 1, OP_SAMPLE_PRELOAD), 1'h0, q);
      repeat (3) @(posedge clk);
      chk("pin_out", 64'(latch), 64'(pout));
      chk("pin_oe", 64'(dir), 64'(poe));
      for (int k = 0; k < 28; k++)
         {exo[k], exe[k]} = {PAT[pos_of(k)], PAT[pos_of(k) - 1]};
      tap_test_ctrl_model_i.set_ir(OP_EXTEST);
      chk("pin_out", 64'(exo), 64'(pout));
      chk("pin_oe", 64'(exe), 64'(poe));
      tap_test_ctrl_model_i.set_ir(4'hF);
      chk("pin_out", 64'(latch), 64'(pout));
      $display("test scan done");
      tap_test_ctrl_model_i.set_ir(OP_TEST_RESET);
      tap_test_ctrl_model_i.pulse(mk(0, 1, 0, OP_TEST_RESET), 1'h1, q);
      repeat (4) @(posedge clk);
      chk("test_reset", 64'h1, 64'(trst));
      tap_test_ctrl_model_i.pulse(mk(0, 1, 0, OP_TEST_RESET), 1'h0, q);
      repeat (4) @(posedge clk);
      chk("test_reset", 64'h0, 64'(trst));
      reg_check(REG_RESET_CAUSE, 8'h10);
      events(1'h0, 1'h1);
      reg_check(REG_RESET_CAUSE, 8'h1E);
      reg_write(REG_RESET_CAUSE, 8'hEF);
      reg_check(REG_RESET_CAUSE, 8'h0E);
      tap_test_ctrl_model_i.pulse(mk(0, 1, 0, OP_TEST_RESET), 1'h1, q);
      tap_test_ctrl_model_i.pulse(mk(0, 1, 0, OP_TEST_RESET), 1'h0, q);
      repeat (4) @(posedge clk);
      reg_check(REG_RESET_CAUSE, 8'h1E);
      events(1'h1, 1'h0);
      reg_check(REG_RESET_CAUSE, 8'h0F);
      $display("test reset cause done");
      finish_test();
   end
endmodule : test_boundary_scan_chain_ctrl
`default_nettype wire
